// ==== inc/lsd_consts.vh ====
// Constants for the segment LCD driver controller
`ifndef LSD_CONSTS_VH
`define LSD_CONSTS_VH
`define LSD_ADDR_DATA0 8'h89
`define LSD_ADDR_DATA1 8'h8A
`define LSD_ADDR_DATA2 8'h8B
`define LSD_ADDR_DATA3 8'h8C
`define LSD_ADDR_DATA4 8'h8D
`define LSD_ADDR_DATA5 8'h8E
`define LSD_ADDR_DATA6 8'h91
`define LSD_ADDR_DATA7 8'h92
`define LSD_ADDR_DATA8 8'h93
`define LSD_ADDR_DATA9 8'h94
`define LSD_ADDR_DATA10 8'h95
`define LSD_ADDR_DATA11 8'h96
`define LSD_ADDR_DATA12 8'h97
`define LSD_ADDR_DATA13 8'h99
`define LSD_ADDR_DATA14 8'h9A
`define LSD_ADDR_DATA15 8'h9B
`define LSD_ADDR_CTRL 8'h9D
`define LSD_CTRL_RESET 8'h00
`define LSD_CTRL_WMASK 8'h7F
`define LSD_DATA_RESET 8'h00
`define LSD_CLKDIV_HI 6
`define LSD_CLKDIV_LO 5
`define LSD_BLANK_BIT 4
`define LSD_SIZE_BIT 3
`define LSD_MUX_HI 2
`define LSD_MUX_LO 1
`define LSD_BIAS_BIT 0
`define LSD_MUX_STATIC 2'h0
`define LSD_MUX_TWO 2'h1
`define LSD_MUX_THREE 2'h2
`define LSD_MUX_FOUR 2'h3
`define LSD_DIV_ONE 2'h0
`define LSD_DIV_TWO 2'h1
`define LSD_DIV_FOUR 2'h2
`define LSD_HALF_PINS 16
`define LSD_SETPOINT_BASE_MV 16'h076C
`define LSD_SETPOINT_STEP_MV 16'h003C
`endif

// ==== rtl/lsd_driver.v ====
// Segment LCD driver controller: data registers, frame timing, contrast mode
`timescale 1ns/1ns
`default_nettype none
`include "lsd_consts.vh"
module lsd_driver (
    // Clock and reset
    input wire clk_sys,
    input wire resetn,
    // Register port (8-bit special function register access)
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    output wire [7:0] reg_rdata,
    // Oscillator tick and loose control bits
    input wire osc_tick,
    input wire display_master_enable,
    input wire display_data_clear,
    input wire [9:0] refresh_prescaler_value,
    // Contrast mode bits and monitor result
    input wire pump_reduced_drive,
    input wire pump_bypass,
    input wire contrast_mode_select,
    input wire battery_monitor_enable,
    input wire battery_low,
    input wire [4:0] contrast_setpoint,
    // Drive outputs: code 0 ground, 1..3 bias levels (3 = full supply)
    output reg [63:0] segment_level,
    output reg [7:0] backplane_level,
    output reg [15:0] target_mv,
    output reg pump_enable,
    output reg pump_low_power,
    output reg supply_regulate,
    output reg supply_bypass,
    output reg [2:0] contrast_mode,
    output reg display_active,
    output reg frame_tick
);
    reg [7:0] data_r [0:15];
    reg [7:0] ctrl_r;
    reg [3:0] sel_idx;
    reg sel_hit;
    reg [1:0] div_cnt_r;
    reg clk_en;
    reg [9:0] pre_cnt_r;
    reg [1:0] com_r;
    reg phase_r;
    wire [1:0] mux_mode = ctrl_r[`LSD_MUX_HI:`LSD_MUX_LO];
    wire [1:0] div_code = ctrl_r[`LSD_CLKDIV_HI:`LSD_CLKDIV_LO];
    wire half_bias = ctrl_r[`LSD_BIAS_BIT];
    wire blank = ctrl_r[`LSD_BLANK_BIT];
    wire size32 = ctrl_r[`LSD_SIZE_BIT];
    wire [1:0] last_com = mux_mode;
    integer k;

    // ==========================================================
    // Register decode
    always @* begin
        sel_hit = 1'b1;
        sel_idx = 4'h0;
        case (reg_addr)
            `LSD_ADDR_DATA0: sel_idx = 4'h0;
            `LSD_ADDR_DATA1: sel_idx = 4'h1;
            `LSD_ADDR_DATA2: sel_idx = 4'h2;
            `LSD_ADDR_DATA3: sel_idx = 4'h3;
            `LSD_ADDR_DATA4: sel_idx = 4'h4;
            `LSD_ADDR_DATA5: sel_idx = 4'h5;
            `LSD_ADDR_DATA6: sel_idx = 4'h6;
            `LSD_ADDR_DATA7: sel_idx = 4'h7;
            `LSD_ADDR_DATA8: sel_idx = 4'h8;
            `LSD_ADDR_DATA9: sel_idx = 4'h9;
            `LSD_ADDR_DATA10: sel_idx = 4'hA;
            `LSD_ADDR_DATA11: sel_idx = 4'hB;
            `LSD_ADDR_DATA12: sel_idx = 4'hC;
            `LSD_ADDR_DATA13: sel_idx = 4'hD;
            `LSD_ADDR_DATA14: sel_idx = 4'hE;
            `LSD_ADDR_DATA15: sel_idx = 4'hF;
            default: sel_hit = 1'b0;
        endcase
    end

    // Unmapped addresses read zero; reserved control bit reads zero
    assign reg_rdata = sel_hit ? data_r[sel_idx] :
                       (reg_addr == `LSD_ADDR_CTRL) ? ctrl_r : 8'h00;

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= `LSD_CTRL_RESET;
            for (k = 0; k < 16; k = k + 1)
                data_r[k] <= `LSD_DATA_RESET;
        end else begin
            if (reg_wr && reg_addr == `LSD_ADDR_CTRL)
                ctrl_r <= reg_wdata & `LSD_CTRL_WMASK;
            // Clear level wins over a same-cycle data write
            if (display_data_clear) begin
                for (k = 0; k < 16; k = k + 1)
                    data_r[k] <= `LSD_DATA_RESET;
            end else if (reg_wr && sel_hit) begin
                data_r[sel_idx] <= reg_wdata;
            end
        end
    end

    // ==========================================================
    // Display clock divider
    always @* begin
        case (div_code)
            `LSD_DIV_ONE: clk_en = osc_tick;
            `LSD_DIV_TWO: clk_en = osc_tick && div_cnt_r[0];
            `LSD_DIV_FOUR: clk_en = osc_tick && (div_cnt_r == 2'h3);
            default: clk_en = 1'b0; // Reserved code stalls the display clock
        endcase
    end

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn)
            div_cnt_r <= 2'h0;
        else if (!display_master_enable)
            div_cnt_r <= 2'h0;
        else if (osc_tick)
            div_cnt_r <= div_cnt_r + 2'h1;
    end

    // ==========================================================
    // Frame timing: each backplane slot has two polarity phases,
    // each phase lasting 2*(prescaler[8:0]+1) display clocks, so one frame
    // spans 4 * backplanes * (prescaler[8:0]+1) display clocks.
    // At-or-above: a prescaler lowered mid-phase ends the phase at once, no counter wrap
    wire slot_done = clk_en && (pre_cnt_r >= {refresh_prescaler_value[8:0], 1'b1});
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pre_cnt_r <= 10'h000;
            com_r <= 2'h0;
            phase_r <= 1'b0;
            frame_tick <= 1'b0;
        end else begin
            frame_tick <= 1'b0;
            if (!display_master_enable) begin
                pre_cnt_r <= 10'h000;
                com_r <= 2'h0;
                phase_r <= 1'b0;
            end else if (clk_en) begin
                if (slot_done) begin
                    pre_cnt_r <= 10'h000;
                    phase_r <= ~phase_r;
                    if (phase_r) begin
                        if (com_r >= last_com) begin
                            com_r <= 2'h0;
                            frame_tick <= 1'b1;
                        end else begin
                            com_r <= com_r + 2'h1;
                        end
                    end
                end else begin
                    pre_cnt_r <= pre_cnt_r + 10'h001;
                end
            end
        end
    end

    // ==========================================================
    // Waveform levels. Full supply = 3; 1/3 bias uses 1 and 2,
    // 1/2 bias uses the mid level, always coded 1 (code 2 is never driven).
    wire [1:0] lvl_hi = 2'h3;
    wire [1:0] lvl_on_un = half_bias ? 2'h1 : 2'h2;
    wire [1:0] lvl_off_un = half_bias ? 2'h1 : 2'h1;
    wire [1:0] seg_off_sel = half_bias ? 2'h1 : 2'h2;

    genvar gb;
    generate
        for (gb = 0; gb < 4; gb = gb + 1) begin : g_bp
            wire used = (gb <= mux_mode);
            wire sel = (com_r == gb);
            reg [1:0] lvl;
            always @* begin
                if (mux_mode == `LSD_MUX_STATIC)
                    lvl = phase_r ? lvl_hi : 2'h0;
                else if (sel)
                    lvl = phase_r ? 2'h0 : lvl_hi;
                else
                    lvl = phase_r ? lvl_on_un : lvl_off_un;
            end
            always @(posedge clk_sys or negedge resetn) begin
                if (!resetn)
                    backplane_level[2*gb+1:2*gb] <= 2'h0;
                else
                    backplane_level[2*gb+1:2*gb] <= (display_active && used) ?
                                                     lvl : 2'h0;
            end
        end
    endgenerate

    genvar gs;
    generate
        for (gs = 0; gs < 32; gs = gs + 1) begin : g_seg
            wire [3:0] nib = data_r[gs / 2][4*(gs%2)+3:4*(gs%2)];
            wire pin_used = (gs < `LSD_HALF_PINS) || size32;
            wire bit_on = nib[com_r] && (com_r <= mux_mode) && !blank;
            reg [1:0] lvl;
            always @* begin
                if (mux_mode == `LSD_MUX_STATIC)
                    lvl = (bit_on ^ phase_r) ? lvl_hi : 2'h0;
                else if (bit_on)
                    lvl = phase_r ? lvl_hi : 2'h0;
                else
                    lvl = phase_r ? seg_off_sel : (half_bias ? 2'h1 : 2'h1);
            end
            always @(posedge clk_sys or negedge resetn) begin
                if (!resetn)
                    segment_level[2*gs+1:2*gs] <= 2'h0;
                else
                    segment_level[2*gs+1:2*gs] <= (display_active && pin_used) ?
                                                   lvl : 2'h0;
            end
        end
    endgenerate

    // ==========================================================
    // Contrast mode and supply path
    localparam [3:0] ST_M1 = 4'b0001;
    localparam [3:0] ST_M2 = 4'b0010;
    localparam [3:0] ST_M3 = 4'b0100;
    localparam [3:0] ST_M4 = 4'b1000;
    reg [3:0] mode_st;
    always @* begin
        // Reduced-drive bit left out of the decode: software may clear it
        case ({pump_bypass, contrast_mode_select, battery_monitor_enable})
            3'b100: mode_st = ST_M1;
            3'b111: mode_st = ST_M2;
            3'b011: mode_st = ST_M3;
            3'b001: mode_st = ST_M4;
            default: mode_st = ST_M1; // Unlisted combos fall back to bypass
        endcase
    end

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            display_active <= 1'b0;
            pump_enable <= 1'b0;
            pump_low_power <= 1'b0;
            supply_regulate <= 1'b0;
            supply_bypass <= 1'b1;
            contrast_mode <= 3'h1;
            target_mv <= `LSD_SETPOINT_BASE_MV;
        end else begin
            display_active <= display_master_enable;
            pump_low_power <= pump_reduced_drive;
            target_mv <= `LSD_SETPOINT_BASE_MV +
                         {11'h000, contrast_setpoint} * `LSD_SETPOINT_STEP_MV;
            case (mode_st)
                ST_M1: begin
                    contrast_mode <= 3'h1;
                    pump_enable <= 1'b0;
                    supply_regulate <= 1'b0;
                    supply_bypass <= 1'b1;
                end
                ST_M2: begin
                    contrast_mode <= 3'h2;
                    pump_enable <= battery_low;
                    supply_regulate <= 1'b0;
                    supply_bypass <= !battery_low;
                end
                ST_M3: begin
                    contrast_mode <= 3'h3;
                    pump_enable <= battery_low;
                    supply_regulate <= !battery_low;
                    supply_bypass <= 1'b0;
                end
                ST_M4: begin
                    contrast_mode <= 3'h4;
                    pump_enable <= 1'b0;
                    supply_regulate <= !battery_low;
                    supply_bypass <= battery_low;
                end
                default: begin
                    contrast_mode <= 3'h1;
                    pump_enable <= 1'b0;
                    supply_regulate <= 1'b0;
                    supply_bypass <= 1'b1;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== dv/lsd_glass.sv ====
// Passive multiplexed segment glass model watching the drive levels
`timescale 1ns/1ns
`default_nettype none
module lsd_glass (
    // Clock and housekeeping
    input wire logic clk_sys,
    input wire logic clear,
    input wire logic [1:0] last_bp,
    input wire logic wide,
    // Drive levels from the controller
    input wire logic [63:0] segment_level,
    input wire logic [7:0] backplane_level,
    // Segments seen darkened since the last clear
    output logic [127:0] lit
);
    integer p, b;
    // ==========================================================
    // Only a full-supply swing darkens; bias levels stay below it
    always @(posedge clk_sys) begin
        if (clear) begin
            lit <= 128'h0;
        end else begin
            for (p = 0; p < 32; p = p + 1) begin
                for (b = 0; b < 4; b = b + 1) begin
                    // Upper sixteen pins reach the glass only in the wide size
                    if ((p < 16 || wide) && b <= last_bp && ({segment_level[2*p +: 2],
                        backplane_level[2*b +: 2]} inside {4'h3, 4'hC})) begin
                        lit[4*p+b] <= 1'b1;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== dv/lsd_driver_chk.sv ====
// Port-level assertion checker for the segment LCD driver
`timescale 1ns/1ns
`default_nettype none
module lsd_driver_chk (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic [7:0] reg_rdata,
    // Control inputs
    input wire logic display_master_enable,
    input wire logic display_data_clear,
    input wire logic pump_bypass,
    input wire logic contrast_mode_select,
    input wire logic battery_monitor_enable,
    input wire logic battery_low,
    input wire logic [4:0] contrast_setpoint,
    // Drive and status outputs
    input wire logic [63:0] segment_level,
    input wire logic [7:0] backplane_level,
    input wire logic [15:0] target_mv,
    input wire logic pump_enable,
    input wire logic supply_bypass,
    input wire logic [2:0] contrast_mode,
    input wire logic display_active
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // ==========================================================
    // Guard: $past still sees reset-time values at the first edge
    logic up_r;
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            up_r <= 1'b0;
        end else begin
            up_r <= 1'b1;
        end
    end
    AST_SETPOINT: assert property (up_r |-> target_mv == 16'h076C +
        16'h003C * $past(contrast_setpoint)) else $error("setpoint voltage wrong");
    AST_ACTIVE: assert property (up_r |-> display_active ==
        $past(display_master_enable)) else $error("active flag does not follow enable");
    AST_DARK: assert property (!display_master_enable [*3] |->
        segment_level == 64'h0 && backplane_level == 8'h00) else $error("drive while off");
    AST_BIT7: assert property (reg_addr == 8'h9D |-> !reg_rdata[7])
        else $error("control bit 7 reads one");
    AST_WRRD: assert property (reg_wr && reg_addr == 8'h89 && !display_data_clear
        ##1 reg_addr == 8'h89 |-> reg_rdata == $past(reg_wdata)) else $error("data lost");
    AST_CLEAR: assert property (display_data_clear ##1 reg_addr == 8'h8A |->
        reg_rdata == 8'h00) else $error("data survives clear");
    AST_MODE2: assert property ((pump_bypass && contrast_mode_select &&
        battery_monitor_enable) [*2] |-> contrast_mode == 3'h2) else $error("mode 2 decode");
    AST_MODE3: assert property ((!pump_bypass && contrast_mode_select &&
        battery_monitor_enable) [*2] |-> contrast_mode == 3'h3) else $error("mode 3 decode");
    AST_PUMP_OFF: assert property ($stable(contrast_mode) && (contrast_mode == 3'h1 ||
        contrast_mode == 3'h4) |-> !pump_enable) else $error("pump on in mode 1 or 4");
    AST_LOW2: assert property ((contrast_mode == 3'h2 && battery_low) [*3] |->
        pump_enable) else $error("pump off on low battery");
    AST_HIGH2: assert property ((contrast_mode == 3'h2 && !battery_low) [*3] |->
        supply_bypass && !pump_enable) else $error("no battery feed");
    AST_LOW4: assert property ((contrast_mode == 3'h4 && battery_low) [*3] |->
        supply_bypass) else $error("no bypass on low battery");
endmodule
bind lsd_driver lsd_driver_chk lsd_driver_chk_inst (.*);
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking testbench for the segment LCD driver
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk_sys = 1'b0, resetn = 1'b0, reg_wr = 1'b0, osc_tick = 1'b0, en = 1'b0;
    logic clr = 1'b0, battery_low = 1'b0, gclr = 1'b0, frame_tick, pump_enable;
    logic supply_bypass, display_active, blank, size;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, backplane_level;
    logic [3:0] mbits = 4'h4;
    logic [4:0] setp = 5'h00;
    logic [9:0] presc = 10'h000;
    logic [1:0] look = 2'h0, mux = 2'h0, div;
    logic [63:0] segment_level;
    logic [15:0] target_mv;
    logic [2:0] contrast_mode;
    logic [127:0] lit, e;
    logic [127:0] exp_q[$];
    logic osc_d = 1'b0, arm = 1'b0, supply_regulate, pump_low_power;
    integer ocnt = 0, fexp = 0, m;
    wire [6:0] sup_seen = {contrast_mode, pump_enable, supply_bypass, supply_regulate,
        pump_low_power};
    logic [7:0] dat[16];
    logic [7:0] at[17] = '{8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h91, 8'h92,
        8'h93, 8'h94, 8'h95, 8'h96, 8'h97, 8'h99, 8'h9A, 8'h9B, 8'h9D};
    logic [3:0] mt[4] = '{4'h4, 4'h7, 4'hB, 4'h9};
    integer bad_count = 0, checks = 0, i, p, b, k, seed;
    lsd_driver lsd_driver_inst (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .osc_tick(osc_tick),
        .display_master_enable(en), .display_data_clear(clr),
        .refresh_prescaler_value(presc), .pump_reduced_drive(mbits[3]),
        .pump_bypass(mbits[2]), .contrast_mode_select(mbits[1]),
        .battery_monitor_enable(mbits[0]), .battery_low(battery_low),
        .contrast_setpoint(setp), .segment_level(segment_level),
        .backplane_level(backplane_level), .target_mv(target_mv), .pump_enable(pump_enable),
        .pump_low_power(pump_low_power), .supply_regulate(supply_regulate),
        .supply_bypass(supply_bypass),
        .contrast_mode(contrast_mode), .display_active(display_active),
        .frame_tick(frame_tick));
    lsd_glass lsd_glass_inst (.clk_sys(clk_sys), .clear(gclr), .last_bp(mux), .wide(size),
        .segment_level(segment_level), .backplane_level(backplane_level), .lit(lit));
    always #10 clk_sys = ~clk_sys;
    always @(negedge clk_sys) osc_tick <= 1'($urandom % 2);
    // ==========================================================
    // Result watcher: pairs each sampled result with the oldest note
    task check(input string nm, input logic [127:0] seen, input logic [127:0] ex);
        checks++;
        if (seen !== ex) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    always @(posedge clk_sys) begin
        if (look == 2'h1) check("reg_rdata", {120'h0, reg_rdata}, exp_q.pop_front());
        else if (look == 2'h2) check("lit", lit, exp_q.pop_front());
        else if (look == 2'h3) begin
            check("sup", {121'h0, sup_seen}, exp_q.pop_front());
            check("target_mv", {112'h0, target_mv}, exp_q.pop_front());
        end
    end
    // Frame length in oscillator ticks; tick delayed one cycle to line up with the pulse
    always @(posedge clk_sys) begin
        osc_d <= osc_tick;
        if (frame_tick === 1'b1) begin
            if (arm) check("frame_len", ocnt + osc_d, fexp);
            ocnt <= 0;
        end else begin
            ocnt <= ocnt + osc_d;
        end
    end
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        look = 2'h1;
        exp_q.push_back({120'h0, d});
        @(negedge clk_sys);
        look = 2'h0;
    endtask
    task wait_frame;
        k = 0;
        while (frame_tick !== 1'b1 && k < 5000) begin
            @(posedge clk_sys);
            k++;
        end
        if (k == 5000) bad_count++;
        @(posedge clk_sys);
    endtask
    task summarize;
        $display("Checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #1000000;
        bad_count++;
        summarize;
    end
    initial begin
        seed = $urandom(85);
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys) resetn = 1'b1;
        for (i = 0; i < 17; i++) rd(at[i], 8'h00);
        rd(8'h90, 8'h00);
        wr(8'h9D, 8'hFF);
        rd(8'h9D, 8'h7F);
        for (i = 0; i < 16; i++) begin
            dat[i] = 8'($urandom);
            wr(at[i], dat[i]);
        end
        rd(8'h89, dat[0]);
        // Four mux modes, then blanking in static mode
        for (i = 0; i < 5; i++) begin
            {mux, blank, size, div} = {2'(i % 4), i == 4, 1'($urandom % 2), 2'(i % 3)};
            presc = 10'($urandom % 4);
            wr(8'h9D, {1'b0, div, blank, size, mux, 1'($urandom % 2)});
            fexp = 4 * (mux + 1) * (presc + 1) * (1 << div);
            en = 1'b1;
            wait_frame;
            arm = 1'b1;
            wait_frame;
            @(negedge clk_sys) gclr = 1'b1;
            @(negedge clk_sys) gclr = 1'b0;
            wait_frame;
            wait_frame;
            for (p = 0; p < 32; p++) for (b = 0; b < 4; b++)
                e[4*p+b] = !blank && (size || p < 16) && b <= mux && dat[p/2][4*(p%2)+b];
            exp_q.push_back(e);
            @(negedge clk_sys) look = 2'h2;
            @(negedge clk_sys) look = 2'h0;
            arm = 1'b0;
        end
        clr = 1'b1;
        wr(8'h8B, 8'h55);
        rd(8'h8A, 8'h00);
        clr = 1'b0;
        for (i = 0; i < 16; i++) rd(at[i], 8'h00);
        // Every contrast mode with the battery high, then low
        for (i = 0; i < 8; i++) begin
            @(negedge clk_sys);
            mbits = mt[i/2];
            if (i >= 4) mbits[3] = 1'($urandom % 2);
            battery_low = 1'(i % 2);
            setp = 5'($urandom);
            repeat (6) @(negedge clk_sys);
            m = i / 2 + 1;
            exp_q.push_back({121'h0, 3'(m), (m == 2 || m == 3) && battery_low,
                m == 1 || (m == 2 && !battery_low) || (m == 4 && battery_low),
                (m == 3 || m == 4) && !battery_low, mbits[3]});
            exp_q.push_back({112'h0, 16'h076C + 16'h003C * setp});
            look = 2'h3;
            @(negedge clk_sys) look = 2'h0;
        end
        en = 1'b0;
        repeat (8) @(negedge clk_sys);
        summarize;
    end
endmodule
`default_nettype wire
